// *** hw/bmam_pkg.sv ***
// Purpose: constants and carriers for the banked memory address map
// Assumes: one clock, synchronous active-low reset
// Notes:   data addresses are 9 bits: two bank bits over a 7-bit offset
package bmam_pkg;

  localparam int          BMAM_PC_W        = 13;
  localparam int          BMAM_WORD_W      = 14;
  localparam int          BMAM_DADDR_W     = 9;
  localparam int          BMAM_OFS_W       = 7;
  localparam logic [12:0] BMAM_RESET_VEC   = 13'h0000;
  localparam logic [12:0] BMAM_INT_VEC     = 13'h0004;
  localparam logic [12:0] BMAM_PC_MASK_8K  = 13'h1fff;
  localparam logic [12:0] BMAM_PC_MASK_4K  = 13'h0fff;
  localparam int          BMAM_BSEL_HI_POS = 6;
  localparam int          BMAM_BSEL_LO_POS = 5;
  localparam logic [6:0]  BMAM_BANK_TOP    = 7'h7f;
  localparam logic [6:0]  BMAM_GPR_BASE    = 7'h20;
  localparam logic [6:0]  BMAM_IND_OFS     = 7'h00;
  // offsets that decode to one shared register in every bank
  localparam logic [6:0]  BMAM_MIR_PC_LOW   = 7'h02;
  localparam logic [6:0]  BMAM_MIR_STATUS   = 7'h03;
  localparam logic [6:0]  BMAM_MIR_PTR      = 7'h04;
  localparam logic [6:0]  BMAM_MIR_PC_LATCH = 7'h0a;
  localparam logic [6:0]  BMAM_MIR_INT_CTRL = 7'h0b;

  typedef struct packed {
    logic       sfr;
    logic       gpr;
    logic       mirror;
    logic [1:0] bank;
    logic [8:0] addr;
  } bmam_data_s;

endpackage : bmam_pkg

// *** hw/bmam_core.sv ***
// Purpose: program counter and data address formation with bank decode
// Assumes: caller steps/jumps the counter; status and pointer fed in
// Notes:   fetch and data paths run in parallel every cycle
`timescale 1ns/1ps

module bmam_core
  import bmam_pkg::*;
#(
  parameter bit LARGE = 1'b1
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_pc_step,
  input  wire logic        i_pc_load,
  input  wire logic [12:0] i_pc_target,
  input  wire logic        i_int_take,
  input  wire logic [7:0]  i_status,
  input  wire logic [7:0]  i_indirect_pointer,
  input  wire logic [6:0]  i_direct_ofs,
  input  wire logic        i_data_req,
  output logic      [12:0] o_fetch_addr,
  output logic             o_fetch_valid,
  output bmam_data_s       o_data
);

  localparam logic [12:0] PC_MASK = LARGE ? BMAM_PC_MASK_8K : BMAM_PC_MASK_4K;

  function automatic logic is_mirror(input logic [6:0] ofs);
    is_mirror = (ofs == BMAM_IND_OFS) || (ofs == BMAM_MIR_PC_LOW) ||
                (ofs == BMAM_MIR_STATUS) || (ofs == BMAM_MIR_PTR) ||
                (ofs == BMAM_MIR_PC_LATCH) || (ofs == BMAM_MIR_INT_CTRL);
  endfunction : is_mirror

  logic [12:0] pc_q;
  logic [12:0] pc_d;
  logic        fv_q;
  bmam_data_s  data_q;
  bmam_data_s  data_d;

  wire logic [12:0] pc_inc     = pc_q + 13'h0001;
  wire logic [12:0] pc_raw     = i_int_take ? BMAM_INT_VEC :
                                 i_pc_load  ? i_pc_target :
                                 i_pc_step  ? pc_inc : pc_q;
  wire logic [1:0]  bank_sel   = {i_status[BMAM_BSEL_HI_POS],
                                  i_status[BMAM_BSEL_LO_POS]};
  wire logic        use_ind    = (i_direct_ofs == BMAM_IND_OFS);
  wire logic [8:0]  direct_a   = {bank_sel, i_direct_ofs};
  wire logic [8:0]  indir_a    = {bank_sel[1], i_indirect_pointer};
  wire logic [8:0]  eff_a      = use_ind ? indir_a : direct_a;
  wire logic [6:0]  eff_ofs    = eff_a[6:0] & BMAM_BANK_TOP;
  wire logic        eff_sfr    = (eff_ofs < BMAM_GPR_BASE);
  wire logic        eff_mir    = is_mirror(eff_ofs);

  always_comb begin
    pc_d = pc_raw & PC_MASK;
    data_d.sfr    = i_data_req & eff_sfr;
    data_d.gpr    = i_data_req & ~eff_sfr;
    data_d.mirror = i_data_req & eff_sfr & eff_mir;
    data_d.bank   = eff_a[8:7];
    data_d.addr   = eff_mir ? {2'b00, eff_ofs} : eff_a;
  end

  // fetch and data registers update independently each cycle
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pc_q   <= BMAM_RESET_VEC;
      fv_q   <= 1'b0;
      data_q <= '0;
    end else begin
      pc_q   <= pc_d;
      fv_q   <= 1'b1;
      data_q <= data_d;
    end
  end

  assign o_fetch_addr  = pc_q;
  assign o_fetch_valid = fv_q;
  assign o_data        = data_q;

  chk_pc_reset_vec: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> pc_q == BMAM_RESET_VEC) else $error("pc not at reset vector");
  chk_int_vector: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_int_take |=> o_fetch_addr == BMAM_INT_VEC) else $error("interrupt vector missed");
  chk_pc_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_fetch_addr & ~PC_MASK) == 13'h0000) else $error("fetch beyond store");
  chk_pc_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_pc_step && !i_pc_load && !i_int_take |=>
    o_fetch_addr == (($past(pc_q) + 13'h0001) & PC_MASK)) else $error("pc step wrong");
  chk_bank_select: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && !use_ind && !eff_mir |=>
    o_data.addr[8:7] == $past(bank_sel)) else $error("bank select wrong");
  chk_direct_addr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && !use_ind && !eff_mir |=>
    o_data.addr == {$past(bank_sel), $past(i_direct_ofs)}) else $error("direct addr wrong");
  chk_region_split: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_data.sfr |-> (o_data.addr[6:0] < BMAM_GPR_BASE) && !o_data.gpr)
    else $error("region split wrong");
  chk_mirror_map: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_data.mirror |-> o_data.addr[8:7] == 2'b00) else $error("mirror not shared");
  chk_indirect: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && use_ind && !eff_mir |=>
    o_data.addr[7:0] == $past(i_indirect_pointer)) else $error("indirect addr wrong");

  chk_load_target: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_pc_load && !i_int_take |=>
    o_fetch_addr == ($past(i_pc_target) & PC_MASK))
    else $error("load target wrong");

  chk_pc_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_pc_step && !i_pc_load && !i_int_take |=>
    o_fetch_addr == $past(o_fetch_addr))
    else $error("pc did not hold");

  chk_int_priority: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_int_take && i_pc_load |=>
    o_fetch_addr == BMAM_INT_VEC)
    else $error("interrupt lost to load");

  chk_int_over_step: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_int_take && i_pc_step |=>
    o_fetch_addr == BMAM_INT_VEC)
    else $error("interrupt lost to step");

  chk_step_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_pc_step && !i_pc_load && !i_int_take && (pc_q == PC_MASK) |=>
    o_fetch_addr == 13'h0000)
    else $error("step did not wrap");

  chk_parallel_paths: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_pc_step && !i_pc_load && !i_int_take && i_data_req |=>
    o_fetch_valid && (o_data.sfr || o_data.gpr))
    else $error("fetch and data not concurrent");

  chk_req_class: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req |=>
    o_data.sfr ^ o_data.gpr)
    else $error("access not classed once");

  chk_no_req_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_data_req |=>
    !o_data.sfr && !o_data.gpr && !o_data.mirror)
    else $error("flags without request");

  chk_mirror_sfr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_data.mirror |->
    o_data.sfr && (o_data.addr[6:0] < BMAM_GPR_BASE))
    else $error("mirror outside special region");

  chk_mirror_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && eff_mir |=>
    o_data.mirror)
    else $error("mirror flag missing");

  chk_mirror_ofs: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && eff_mir |=>
    o_data.addr == {2'b00, $past(eff_ofs)})
    else $error("mirror address wrong");

  chk_no_mirror_gpr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && !eff_sfr |=>
    !o_data.mirror)
    else $error("static ram marked mirrored");

  chk_bank_field: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && !use_ind |=>
    o_data.bank == $past(bank_sel))
    else $error("bank field wrong");

  chk_ind_bank: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && use_ind |=>
    o_data.bank == {$past(i_status[BMAM_BSEL_HI_POS]), $past(i_indirect_pointer[7])})
    else $error("indirect bank wrong");

  chk_ind_high: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && use_ind && !eff_mir |=>
    o_data.addr[8] == $past(i_status[BMAM_BSEL_HI_POS]))
    else $error("indirect high bit wrong");

  chk_sfr_each_bank: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && !use_ind && (i_direct_ofs < BMAM_GPR_BASE) |=>
    o_data.sfr)
    else $error("special region missing");

  chk_direct_gpr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_data_req && !use_ind && (i_direct_ofs >= BMAM_GPR_BASE) |=>
    o_data.gpr && (o_data.addr[6:0] == $past(i_direct_ofs)))
    else $error("static ram offset wrong");

  chk_gpr_region: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_data.gpr |->
    (o_data.addr[6:0] >= BMAM_GPR_BASE) && !o_data.sfr)
    else $error("static ram region wrong");

  chk_fetch_valid: assert property (@(posedge i_ref_clk)
    i_rst_n |=>
    o_fetch_valid)
    else $error("fetch not valid");

  chk_valid_reset: assert property (@(posedge i_ref_clk)
    !i_rst_n |=>
    !o_fetch_valid)
    else $error("fetch valid in reset");

  chk_data_reset: assert property (@(posedge i_ref_clk)
    !i_rst_n |=>
    o_data == '0)
    else $error("data bus not cleared");

  chk_reset_start: assert property (@(posedge i_ref_clk)
    $rose(i_rst_n) |->
    o_fetch_addr == BMAM_RESET_VEC)
    else $error("start not at reset vector");

endmodule : bmam_core

// *** bench/bmam_tb.sv ***
// Purpose: directed and random bench for the banked memory address map
// Assumes: outputs settle just after the rising edge; inputs move on the falling edge
// Notes:   driver queues expectations, a watcher pops and compares them
`timescale 1ns/1ps
module testbench;
  import bmam_pkg::*;
  logic        i_ref_clk = 0, i_rst_n = 0, i_pc_step = 0, i_pc_load = 0;
  logic        i_int_take = 0, i_data_req = 0, o_fetch_valid;
  logic [12:0] i_pc_target = 0, o_fetch_addr, o_fetch_addr_4k, pc_m = 0;
  logic [7:0]  i_status = 0, i_indirect_pointer = 0;
  logic [6:0]  i_direct_ofs = 1;
  logic [15:0] a, r = 16'h005b;
  logic [28:0] e, q[$];
  bmam_data_s  o_data, d_m;
  int          bad_count = 0, checked = 0;
  bmam_core #(.LARGE(1'b1)) i_bmam_core(.i_ref_clk, .i_rst_n, .i_pc_step, .i_pc_load,
    .i_pc_target, .i_int_take, .i_status, .i_indirect_pointer, .i_direct_ofs, .i_data_req,
    .o_fetch_addr, .o_fetch_valid, .o_data);
  bmam_core #(.LARGE(1'b0)) i_bmam_core_4k(.i_ref_clk, .i_rst_n, .i_pc_step, .i_pc_load,
    .i_pc_target, .i_int_take, .i_status, .i_indirect_pointer, .i_direct_ofs, .i_data_req,
    .o_fetch_addr(o_fetch_addr_4k), .o_fetch_valid(), .o_data());
  initial forever #20 i_ref_clk = ~i_ref_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [13:0] s, input logic [13:0] x);
    checked++;
    if (s !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic drv(input logic s, l, it, rq, input logic [12:0] t,
                     input logic [7:0] st, p, input logic [6:0] o);
    logic [8:0] ea;
    logic       mir;
    @(negedge i_ref_clk);
    {i_pc_step, i_pc_load, i_int_take, i_data_req, i_pc_target} = {s, l, it, rq, t};
    {i_status, i_indirect_pointer, i_direct_ofs} = {st, p, o};
    if (it) pc_m = BMAM_INT_VEC;
    else if (l) pc_m = t & BMAM_PC_MASK_8K;
    else if (s) pc_m = (pc_m + 13'h0001) & BMAM_PC_MASK_8K;
    // effective address: pointer for offset 00h, else bank bits over offset
    ea         = (o == BMAM_IND_OFS) ? {st[6], p} : {st[6:5], o};
    mir        = ea[6:0] inside {BMAM_IND_OFS, BMAM_MIR_PC_LOW, BMAM_MIR_STATUS, BMAM_MIR_PTR,
                                 BMAM_MIR_PC_LATCH, BMAM_MIR_INT_CTRL};
    d_m.sfr    = rq & (ea[6:0] < BMAM_GPR_BASE);
    d_m.gpr    = rq & (ea[6:0] >= BMAM_GPR_BASE);
    d_m.mirror = rq & mir;
    d_m.bank   = ea[8:7];
    d_m.addr   = mir ? {2'b00, ea[6:0]} : ea;
    q.push_back({o == BMAM_IND_OFS, rq, d_m, pc_m});
  endtask : drv
  initial forever begin
    @(posedge i_ref_clk);
    #1;
    if (i_rst_n && q.size() > 0) begin
      e = q.pop_front();
      chk("fetch_valid", {13'h0, o_fetch_valid}, 14'h0001);
      chk("fetch_addr", {1'b0, o_fetch_addr}, {1'b0, e[12:0]});
      if (e[27] && e[28]) chk("ind_addr", {5'h0, o_data.addr}, {5'h0, e[21:13]});
      chk("data", o_data, e[26:13]);
      chk("fetch_addr_4k", {1'b0, o_fetch_addr_4k}, {1'b0, e[12:0] & BMAM_PC_MASK_4K});
    end
  end
  initial begin
    #(40 * 400);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge i_ref_clk);
    i_rst_n = 1;
    drv(0, 0, 0, 0, 13'h0000, 8'h00, 8'h00, 7'h01);
    drv(0, 1, 1, 1, 13'h0ff0, 8'h60, 8'h00, 7'h25);
    drv(1, 1, 0, 1, 13'h1fff, 8'h20, 8'h00, 7'h03);
    drv(1, 0, 0, 1, 13'h0000, 8'h40, 8'h00, 7'h1f);
    drv(0, 0, 0, 1, 13'h0000, 8'h40, 8'h85, 7'h00);
    repeat (200) begin
      r = lfsr(r);
      a = r;
      r = lfsr(r);
      drv(a[0], a[3:1] == 0, a[7:4] == 0, a[8], r[12:0], a[15:8], r[15:8], r[6:0] ^ a[6:0]);
    end
    repeat (2) @(negedge i_ref_clk);
    complete_run();
  end
endmodule : testbench
